/* File: hw/lcdc_pkg.sv */
// Package with constants and types for the LCD driver command interpreter
package lcdc_pkg;

  // ---------------------------------------------------------------------------
  // Command opcodes (upper bits) and field layout
  // ---------------------------------------------------------------------------
  localparam logic [4:0] OP_IFACE    = 5'h00;  // Interface control, bits 7:3
  localparam logic [4:0] OP_SWRESET  = 5'h02;  // Software reset, bits 7:3
  localparam logic [4:0] OP_DUTY     = 5'h04;  // Duty selection
  localparam logic [4:0] OP_BIAS     = 5'h06;  // Bias selection
  localparam logic [4:0] OP_POWER    = 5'h0a;  // Power circuit enables
  localparam logic [4:0] OP_BOOSTF   = 5'h10;  // Booster frequency
  localparam logic [4:0] OP_RATIO    = 5'h12;  // Regulator divider ratio
  localparam logic [1:0] OP_VOLUME   = 2'h3;   // Volume prefix in bits 7:6
  localparam int         PS_BIT      = 0;      // Parallel/serial select position
  localparam int         LR_BIT      = 1;      // Output direction position
  localparam int         M_BIT       = 2;      // Frame direction position

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] RST_IFACE   = 3'h0;   // Serial data, default directions
  localparam logic [2:0] RST_DUTY    = 3'h0;   // Pure segment mode
  localparam logic [2:0] RST_BIAS    = 3'h0;   // First bias setting
  localparam logic [2:0] RST_POWER   = 3'h0;   // All power circuits off
  localparam logic [2:0] RST_BOOSTF  = 3'h0;   // Lowest booster frequency
  localparam logic [2:0] RST_RATIO   = 3'h0;   // Smallest ratio
  localparam logic [5:0] RST_VOLUME  = 6'h00;  // Volume code zero
  localparam logic [5:0] VOL_MAX     = 6'h3f;  // Top level, sixty-three
  localparam logic [2:0] BITS_LAST   = 3'h7;   // Index of eighth bit
  localparam logic [2:0] DUTY_SEG    = 3'h0;   // Duty code of pure segment mode

  // ---------------------------------------------------------------------------
  // Receiver states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,  // Bus free, waiting for start
    RX_SHIFT = 2'b01,  // Collecting command bits
    RX_RESET = 2'b10   // Software reset held until stop
  } lcdc_rx_t;

endpackage : lcdc_pkg

/* File: hw/lcdc_sync.sv */
// Two-stage synchroniser with edge outputs for the command link pins
`timescale 1ns/1ns
module lcdc_sync (
  input  wire logic ref_clk,   // System clock
  input  wire logic rst,       // Synchronous reset, high
  input  wire logic clkEn,     // Freezes state when low
  input  wire logic pinIn,     // Asynchronous pin
  output logic      level,     // Synchronised level
  output logic      rise,      // One-cycle rising pulse
  output logic      fall       // One-cycle falling pulse
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic meta;   // First stage, read only by second
    logic sync;   // Second stage
    logic prev;   // Delayed for edge detection
  } lcdc_sync_t;

  lcdc_sync_t s_q, s_d;

  // Next-state logic
  always_comb begin
    s_d      = s_q;
    s_d.meta = pinIn;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  // Registers; idle line is high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '1;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign level = s_q.sync;
  assign rise  = s_q.sync & ~s_q.prev;
  assign fall  = ~s_q.sync & s_q.prev;

endmodule : lcdc_sync

/* File: hw/lcdc_cmd.sv */
// Serial command receiver and configuration registers of the LCD driver
`timescale 1ns/1ns
module lcdc_cmd (
  input  wire logic       ref_clk,          // System clock, 25 MHz
  input  wire logic       rst,              // Synchronous reset, high
  input  wire logic       clkEn,            // Freezes all state when low
  input  wire logic       cmdClkIn,         // Command clock pin level
  output logic            cmdClkOut,        // Command clock drive, never driven
  output logic            cmdClkOe_n,       // Command clock enable, low drives
  input  wire logic       cmdSerialDataIn,  // Command data pin level
  output logic            cmdSerialDataOut, // Command data drive, never driven
  output logic            cmdSerialDataOe_n,// Command data enable, low drives
  input  wire logic       displayBlank_n,   // Display blank pin, low blanks
  input  wire logic [3:0] dispData,         // Display data bus pins
  output logic [3:0]      dataNibble,       // Accepted display data
  output logic            parallelMode,     // One when four lines used
  output logic            lrDir,            // Output direction select
  output logic            frameDir,         // Frame direction select
  output logic [2:0]      dutySel,          // Duty selection code
  output logic [2:0]      biasSel,          // Bias selection code
  output logic [2:0]      boostFreq,        // Booster frequency code
  output logic            boosterOn,        // Booster enable, gated by mode
  output logic            regulatorOn,      // Regulator enable, gated by mode
  output logic            followerOn,       // Follower enable, gated by mode
  output logic [5:0]      contrastVolumeLevel, // Alpha level from volume code
  output logic [2:0]      regulatorDividerRatio, // Ratio code
  output logic            blankActive,      // Drive outputs forced to ground
  output logic            softResetActive,  // Software reset in progress
  output logic            frameActive       // Command frame open
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    lcdc_pkg::lcdc_rx_t rx;       // Receiver state
    logic [7:0] shift;            // Bits of the byte in progress
    logic [2:0] bitCnt;           // Bits received so far
    logic [2:0] iface;            // M, LR, PS
    logic [2:0] duty;             // Duty code
    logic [2:0] bias;             // Bias code
    logic [2:0] power;            // B, R, F enables as written
    logic [2:0] boostF;           // Booster frequency
    logic [2:0] ratio;            // Divider ratio
    logic [5:0] volume;           // Volume code
    logic       blankSync0;       // Blank pin first stage
    logic       blankSync1;       // Blank pin second stage
    logic [3:0] dataSync0;        // Data pins first stage
    logic [3:0] dataSync1;        // Data pins second stage
    logic [3:0] nibble;           // Accepted display data
  } lcdc_cmd_t;

  lcdc_cmd_t s_q, s_d;

  logic sclLevel, sclRise;        // Synchronised command clock
  logic sdaLevel, sdaRise, sdaFall; // Synchronised command data
  logic startCond, stopCond;      // Bus conditions
  logic [7:0] byteNext;           // Byte including current bit

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  lcdc_sync uSyncClk (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .pinIn   (cmdClkIn),
    .level   (sclLevel),
    .rise    (sclRise),
    .fall    ()
  );

  lcdc_sync uSyncData (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .pinIn   (cmdSerialDataIn),
    .level   (sdaLevel),
    .rise    (sdaRise),
    .fall    (sdaFall)
  );

  // Start and stop detection with clock high
  assign startCond = sdaFall & sclLevel;
  assign stopCond  = sdaRise & sclLevel;
  assign byteNext  = {s_q.shift[6:0], sdaLevel};

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.blankSync0 = displayBlank_n;
    s_d.blankSync1 = s_q.blankSync0;
    s_d.dataSync0  = dispData;
    s_d.dataSync1  = s_q.dataSync0;
    // Serial mode reads only the first line
    if (s_q.iface[lcdc_pkg::PS_BIT]) begin
      s_d.nibble = s_q.dataSync1;
    end else begin
      s_d.nibble = {3'h0, s_q.dataSync1[0]};
    end
    case (s_q.rx)
      lcdc_pkg::RX_IDLE: begin
        // Waiting for start on the only command path
        if (startCond) begin
          s_d.rx     = lcdc_pkg::RX_SHIFT;
          s_d.bitCnt = 3'h0;
        end
      end
      lcdc_pkg::RX_SHIFT: begin
        if (stopCond) begin
          // Stop ends the frame, partial byte dropped
          s_d.rx = lcdc_pkg::RX_IDLE;
        end else if (startCond) begin
          // Repeated start restarts byte assembly
          s_d.bitCnt = 3'h0;
        end else if (sclRise) begin
          s_d.shift  = byteNext;
          s_d.bitCnt = s_q.bitCnt + 3'h1;
          if (s_q.bitCnt == lcdc_pkg::BITS_LAST) begin
            // Full byte: decode; frame stays open for chaining
            if (byteNext[7:6] == lcdc_pkg::OP_VOLUME) begin
              s_d.volume = byteNext[5:0];
            end else if (byteNext[7:3] == lcdc_pkg::OP_IFACE) begin
              s_d.iface = byteNext[2:0];
            end else if (byteNext[7:3] == lcdc_pkg::OP_SWRESET) begin
              if (byteNext[0]) begin
                s_d.rx = lcdc_pkg::RX_RESET;
              end
            end else if (byteNext[7:3] == lcdc_pkg::OP_DUTY) begin
              s_d.duty = byteNext[2:0];
            end else if (byteNext[7:3] == lcdc_pkg::OP_BIAS) begin
              s_d.bias = byteNext[2:0];
            end else if (byteNext[7:3] == lcdc_pkg::OP_POWER) begin
              s_d.power = byteNext[2:0];
            end else if (byteNext[7:3] == lcdc_pkg::OP_BOOSTF) begin
              s_d.boostF = byteNext[2:0];
            end else if (byteNext[7:3] == lcdc_pkg::OP_RATIO) begin
              s_d.ratio = byteNext[2:0];
            end
          end
        end
      end
      lcdc_pkg::RX_RESET: begin
        // Registers held at defaults; further bytes ignored until stop
        s_d.iface  = lcdc_pkg::RST_IFACE;
        s_d.duty   = lcdc_pkg::RST_DUTY;
        s_d.bias   = lcdc_pkg::RST_BIAS;
        s_d.power  = lcdc_pkg::RST_POWER;
        s_d.boostF = lcdc_pkg::RST_BOOSTF;
        s_d.ratio  = lcdc_pkg::RST_RATIO;
        s_d.volume = lcdc_pkg::RST_VOLUME;
        if (stopCond) begin
          s_d.rx = lcdc_pkg::RX_IDLE;
        end
      end
      default: begin
        s_d.rx = lcdc_pkg::RX_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q            <= '0;
      s_q.rx         <= lcdc_pkg::RX_IDLE;
      s_q.iface      <= lcdc_pkg::RST_IFACE;
      s_q.duty       <= lcdc_pkg::RST_DUTY;
      s_q.bias       <= lcdc_pkg::RST_BIAS;
      s_q.power      <= lcdc_pkg::RST_POWER;
      s_q.boostF     <= lcdc_pkg::RST_BOOSTF;
      s_q.ratio      <= lcdc_pkg::RST_RATIO;
      s_q.volume     <= lcdc_pkg::RST_VOLUME;
      s_q.blankSync0 <= 1'b0;
      s_q.blankSync1 <= 1'b0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic powerAllowed;  // Power circuits permitted in this duty mode
  assign powerAllowed = (s_q.duty != lcdc_pkg::DUTY_SEG);

  assign cmdClkOut             = 1'b0;  // Device only listens on the link
  assign cmdClkOe_n            = 1'b1;
  assign cmdSerialDataOut      = 1'b0;
  assign cmdSerialDataOe_n     = 1'b1;
  assign dataNibble            = s_q.nibble;
  assign parallelMode          = s_q.iface[lcdc_pkg::PS_BIT];
  assign lrDir                 = s_q.iface[lcdc_pkg::LR_BIT];
  assign frameDir              = s_q.iface[lcdc_pkg::M_BIT];
  assign dutySel               = s_q.duty;
  assign biasSel               = s_q.bias;
  assign boostFreq             = s_q.boostF;
  assign boosterOn             = s_q.power[2] & powerAllowed;
  assign regulatorOn           = s_q.power[1] & powerAllowed;
  assign followerOn            = s_q.power[0] & powerAllowed;
  assign contrastVolumeLevel   = lcdc_pkg::VOL_MAX - s_q.volume;
  assign regulatorDividerRatio = s_q.ratio;
  assign blankActive           = ~s_q.blankSync1;
  assign softResetActive       = (s_q.rx == lcdc_pkg::RX_RESET);
  assign frameActive           = (s_q.rx != lcdc_pkg::RX_IDLE);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence startSeen_s;
    (s_q.rx == lcdc_pkg::RX_IDLE) && startCond && clkEn;
  endsequence

  sequence stopSeen_s;
    (s_q.rx != lcdc_pkg::RX_IDLE) && stopCond && clkEn;
  endsequence

  // Eighth bit of a volume command taken in an open frame
  sequence volWrite_s;
    clkEn && (s_q.rx == lcdc_pkg::RX_SHIFT) && !stopCond && !startCond && sclRise
      && (s_q.bitCnt == lcdc_pkg::BITS_LAST) && (byteNext[7:6] == 2'h3);
  endsequence

  property startOpens_p;
    @(posedge ref_clk) disable iff (rst) startSeen_s |=> frameActive;
  endproperty

  property stopCloses_p;
    @(posedge ref_clk) disable iff (rst) stopSeen_s |=> !frameActive;
  endproperty

  start_opens_a: assert property (startOpens_p) else $error("Start did not open frame");
  stop_closes_a: assert property (stopCloses_p) else $error("Stop did not close frame");
  power_gated_a: assert property (@(posedge ref_clk) disable iff (rst)
    (dutySel == lcdc_pkg::DUTY_SEG) |-> !(boosterOn || regulatorOn || followerOn))
    else $error("Power enabled in segment mode");
  power_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
    powerAllowed |-> ({boosterOn, regulatorOn, followerOn} == s_q.power))
    else $error("Power enable mismatch");
  volume_map_a: assert property (@(posedge ref_clk) disable iff (rst)
    volWrite_s |=> (contrastVolumeLevel == ~$past(byteNext[5:0])))
    else $error("Volume level not inverse of code");
  volume_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    volWrite_s |=> (s_q.volume == $past(byteNext[5:0])))
    else $error("Volume command not stored");
  reset_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (softResetActive && clkEn) |=> ((s_q.power == lcdc_pkg::RST_POWER) && frameActive) || !softResetActive)
    else $error("Software reset not holding defaults");
  serial_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !parallelMode) |=> (dataNibble[3:1] == 3'h0))
    else $error("Upper lines used in serial mode");
  idle_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!frameActive && clkEn && !startCond) |=> !frameActive)
    else $error("Frame opened without start");

endmodule : lcdc_cmd

/* File: testbench/lcdc_host_model.sv */
// Host model that drives the two-wire command link of the LCD driver
`timescale 1ns/1ns
module lcdc_host_model (
  input  wire logic ref_clk,  // Timing reference for link edges
  output logic      cmdClk,   // Command clock line driven by host
  output logic      cmdData   // Command data line driven by host
);
  // ---------------------------------------------------------------------------
  // Link pacing
  // ---------------------------------------------------------------------------
  int unsigned halfCycles = 4;  // System cycles per link level, raise to go slow

  // Bus idles with both lines high
  initial begin
    cmdClk  = 1'b1;
    cmdData = 1'b1;
  end

  // Holds the present line levels long enough to be synchronised
  task automatic hold_level();
    repeat (halfCycles) @(negedge ref_clk);
  endtask : hold_level

  // Data falls while clock is high
  task automatic start_cond();
    @(negedge ref_clk);
    cmdData = 1'b0;
    hold_level();
  endtask : start_cond

  // Sends the top count bits, first bit first, data set while clock low
  task automatic send_bits(input logic [7:0] value, input int count);
    for (int i = 7; i > 7 - count; i--) begin
      cmdClk = 1'b0;
      hold_level();
      cmdData = value[i];
      hold_level();
      cmdClk = 1'b1;
      hold_level();
    end
  endtask : send_bits

  // Data rises while clock is high, then bus returns to idle
  task automatic stop_cond();
    cmdClk = 1'b0;
    hold_level();
    cmdData = 1'b0;
    hold_level();
    cmdClk = 1'b1;
    hold_level();
    cmdData = 1'b1;
    hold_level();
  endtask : stop_cond
endmodule : lcdc_host_model

/* File: testbench/lcd_driver_command_config_tb.sv */
// Self-checking testbench for the LCD driver command interpreter
`timescale 1ns/1ns
module lcd_driver_command_config_tb;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic       ref_clk        = 1'b0;  // 25 MHz system clock
  logic       rst            = 1'b1;  // Synchronous reset
  logic       displayBlank_n = 1'b0;  // Blank held during power-up
  logic [3:0] dispData       = 4'h0;  // Display data pins
  logic       hostClk, hostData;       // Host line drive
  logic       clkWire, dataWire;       // Resolved pulled-up lines
  logic       cmdClkOut, cmdClkOe_n, cmdSerialDataOut, cmdSerialDataOe_n;
  logic [3:0] dataNibble;                // Accepted display data
  logic       parallelMode, lrDir, frameDir, boosterOn, regulatorOn, followerOn;
  logic [2:0] dutySel, biasSel, boostFreq, regulatorDividerRatio;
  logic [5:0] contrastVolumeLevel;       // Level from volume code
  logic       blankActive, softResetActive, frameActive;
  int         failures    = 0;           // Mismatch count
  int         comparisons = 0;           // Compare count
  logic [5:0] volCodes[4] = '{6'h00, 6'h01, 6'h10, 6'h1f};  // Volume table, commands kept under the accurate limit

  // Clock generation
  always #20 ref_clk = ~ref_clk;

  // Open-drain lines: low when any enabled driver pulls low
  assign clkWire  = hostClk & (cmdClkOe_n | cmdClkOut);
  assign dataWire = hostData & (cmdSerialDataOe_n | cmdSerialDataOut);

  // ---------------------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------------------
  lcdc_host_model i_lcdc_host_model (.ref_clk(ref_clk), .cmdClk(hostClk), .cmdData(hostData));

  lcdc_cmd i_lcdc_cmd (
    .ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .cmdClkIn(clkWire), .cmdClkOut(cmdClkOut),
    .cmdClkOe_n(cmdClkOe_n), .cmdSerialDataIn(dataWire), .cmdSerialDataOut(cmdSerialDataOut),
    .cmdSerialDataOe_n(cmdSerialDataOe_n), .displayBlank_n(displayBlank_n), .dispData(dispData),
    .dataNibble(dataNibble), .parallelMode(parallelMode), .lrDir(lrDir), .frameDir(frameDir),
    .dutySel(dutySel), .biasSel(biasSel), .boostFreq(boostFreq), .boosterOn(boosterOn),
    .regulatorOn(regulatorOn), .followerOn(followerOn), .contrastVolumeLevel(contrastVolumeLevel),
    .regulatorDividerRatio(regulatorDividerRatio), .blankActive(blankActive),
    .softResetActive(softResetActive), .frameActive(frameActive)
  );

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Compares one value and counts the outcome
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expected);
    comparisons++;
    if (seen !== expected) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, expected, seen);
    end
  endtask : check

  // Lets synchroniser and register latency pass
  task automatic settle();
    repeat (6) @(negedge ref_clk);
  endtask : settle

  // Sends whole commands chained in one start/stop frame
  task automatic frame(input logic [7:0] cmds[$]);
    i_lcdc_host_model.start_cond();
    foreach (cmds[i]) i_lcdc_host_model.send_bits(cmds[i], 8);
    i_lcdc_host_model.stop_cond();
    settle();
  endtask : frame

  // Prints counts and verdict, ends the run
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Watchdog against a hung link
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    final_report();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    settle();
    check("blank at power-up", 8'(blankActive), 8'h01);
    check("volume level default", 8'(contrastVolumeLevel), 8'h3f);
    check("power default", 8'({boosterOn, regulatorOn, followerOn}), 8'h00);
    check("link never driven", 8'({cmdClkOe_n, cmdSerialDataOe_n}), 8'h03);
    displayBlank_n = 1'b1;
    settle();
    check("blank released", 8'(blankActive), 8'h00);
    // Interface fields, then both data bus modes
    frame('{8'h06});
    check("interface fields", 8'({frameDir, lrDir, parallelMode}), 8'h06);
    dispData = 4'hf;
    settle();
    check("serial nibble", 8'(dataNibble), 8'h01);
    frame('{8'h01});
    dispData = 4'h1;
    settle();
    check("parallel mode", 8'(parallelMode), 8'h01);
    check("parallel nibble", 8'(dataNibble), 8'h01);
    // Power gating by duty mode, commands chained
    frame('{8'h20, 8'h57});
    check("power in segment mode", 8'({boosterOn, regulatorOn, followerOn}), 8'h00);
    frame('{8'h21});
    check("power in mixed mode", 8'({boosterOn, regulatorOn, followerOn}), 8'h07);
    // Bias and booster frequency chained in one frame
    frame('{8'h35, 8'h86});
    check("bias code", 8'(biasSel), 8'h05);
    check("booster frequency", 8'(boostFreq), 8'h06);
    check("duty code", 8'(dutySel), 8'h01);
    for (int v = 0; v < 8; v++) begin
      frame('{8'h50 | 8'(v)});
      check("power enables", 8'({boosterOn, regulatorOn, followerOn}), 8'(v));
    end
    foreach (volCodes[i]) begin
      frame('{{2'b11, volCodes[i]}});
      check("volume level", 8'(contrastVolumeLevel), 8'(6'h3f - volCodes[i]));
    end
    // Ratio codes with a slow host
    i_lcdc_host_model.halfCycles = 10;
    for (int v = 0; v < 8; v++) begin
      frame('{8'h90 | 8'(v)});
      check("divider ratio", 8'(regulatorDividerRatio), 8'(v));
    end
    i_lcdc_host_model.halfCycles = 4;
    // Partial byte is dropped at stop
    i_lcdc_host_model.start_cond();
    settle();
    check("frame open", 8'(frameActive), 8'h01);
    i_lcdc_host_model.send_bits(8'h93, 4);
    i_lcdc_host_model.stop_cond();
    settle();
    check("frame closed", 8'(frameActive), 8'h00);
    check("ratio after partial", 8'(regulatorDividerRatio), 8'h07);
    // Software reset chained with a ratio byte, later byte ignored until stop
    i_lcdc_host_model.start_cond();
    i_lcdc_host_model.send_bits(8'h11, 8);
    i_lcdc_host_model.send_bits(8'h93, 8);
    settle();
    check("reset held", 8'(softResetActive), 8'h01);
    check("ratio during reset", 8'(regulatorDividerRatio), 8'h00);
    i_lcdc_host_model.stop_cond();
    settle();
    check("reset released", 8'(softResetActive), 8'h00);
    check("volume after reset", 8'(contrastVolumeLevel), 8'h3f);
    check("power after reset", 8'({boosterOn, regulatorOn, followerOn}), 8'h00);
    frame('{8'h93});
    check("ratio after reset", 8'(regulatorDividerRatio), 8'h03);
    // Reset command with its action bit clear changes nothing
    frame('{8'h10});
    check("reset bit clear", 8'(softResetActive), 8'h00);
    check("ratio kept", 8'(regulatorDividerRatio), 8'h03);
    // Power-down blanks outputs first
    displayBlank_n = 1'b0;
    settle();
    check("blank at power-down", 8'(blankActive), 8'h01);
    final_report();
  end
endmodule : lcd_driver_command_config_tb
